// [hw/sfl_ctrl.v]
// What this block does
// - Phase word seeds modulator, steps 360/modulus
// - Phase word held until next frequency write
// - Low ground bit grounds both pump outputs
// - Polarity bit one positive, zero negative
// - Nine-bit timers tick at quarter reference rate
// - Timer select chooses which counter loads
// - Frequency write starts timers, switches closed
// - Current timer expiry halves current six steps
// - Stay powered down until setup writes done
// - Both amp bits high power amp down
// - Pump power-down forces dividers, tristate, resets
// - Counter reset holds counters until frequency write
// - Three-state bit floats pump outputs
// - Mode word selects dither and lock threshold
// - Diagnostic pin routes selected internal signal
// - Next reference cycle loads divider, fast lock
// - Select code zero writes frequency word
`timescale 1ns/100ps
`include "sfl_defines.vh"
module sfl_ctrl (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        load_enable_strobe,
  input  wire        pfd_ref,
  input  wire        fb_div,
  input  wire        lock_detect_raw,
  output reg  [7:0]  int_value_r,
  output reg  [11:0] fractional_numerator_r,
  output reg  [11:0] fractional_modulus_r,
  output reg  [11:0] modulator_seed_r,
  output reg         seed_load_r,
  output reg         pump_ground_n_r,
  output reg         pfd_positive_r,
  output reg         bandwidth_switch_a_r,
  output reg         bandwidth_switch_b_r,
  output reg         bandwidth_switch_c_r,
  output reg  [6:0]  pump_current_mult_r,
  output reg         amp_power_down_r,
  output reg         pump_power_down_r,
  output reg         dividers_load_r,
  output reg         pump_tristate_r,
  output reg         lock_detect_reset_r,
  output reg         ref_buffer_en_r,
  output reg         dither_en_r,
  output reg         lock_thresh_10ns_r,
  output reg         diagnostic_output_pin_r,
  output reg         device_active_r
);

  localparam NPIN = 6;
  localparam P_SCK = 0;
  localparam P_SDI = 1;
  localparam P_LE  = 2;
  localparam P_REF = 3;
  localparam P_FB  = 4;
  localparam P_LD  = 5;

  reg  [NPIN-1:0]              sync1_r;
  reg  [NPIN-1:0]              sync2_r;
  reg  [NPIN-1:0]              sync3_r;
  reg  [`SFL_WORD_W-1:0]       shift_r;
  reg  [`SFL_MOD_W-1:0]        mod_hold_r;
  reg  [`SFL_MOD_W-1:0]        phase_hold_r;
  reg  [`SFL_INT_W-1:0]        int_hold_r;
  reg  [`SFL_FRACTIONAL_NUMERATOR_W-1:0]       fractional_numerator_hold_r;
  reg  [`SFL_TMR_W-1:0]        tmr_cur_load_r;
  reg  [`SFL_TMR_W-1:0]        tmr_swab_load_r;
  reg  [`SFL_TMR_W-1:0]        tmr_swc_load_r;
  reg  [`SFL_TMR_W-1:0]        tmr_cur_r;
  reg  [`SFL_TMR_W-1:0]        tmr_swab_r;
  reg  [`SFL_TMR_W-1:0]        tmr_swc_r;
  reg  [1:0]                   presc_r;
  reg  [4:0]                   pd_r;
  reg  [3:0]                   dmux_r;
  reg                          pend_r;
  reg                          halted_r;
  reg                          ramp_r;
  reg                          seen_phase_r;
  reg                          seen_mod_r;
  reg                          diag_nxt;

  wire sck_rise = sync2_r[P_SCK] & ~sync3_r[P_SCK];
  wire le_rise  = sync2_r[P_LE] & ~sync3_r[P_LE];
  wire ref_rise = sync2_r[P_REF] & ~sync3_r[P_REF];
  wire qtick    = ref_rise & (presc_r == `SFL_TMR_PRESC);
  wire [2:0] sel = shift_r[2:0];

  function sel_is;
    input [2:0] s;
    input [2:0] code;
    begin
      sel_is = (s == code);
    end
  endfunction

  wire wr_freq  = le_rise & sel_is(sel, `SFL_SEL_FREQ);
  wire wr_mod   = le_rise & sel_is(sel, `SFL_SEL_MODDIV);
  wire wr_phase = le_rise & sel_is(sel, `SFL_SEL_PHASE);
  wire wr_func  = le_rise & sel_is(sel, `SFL_SEL_FUNC);
  wire wr_tmr   = le_rise & sel_is(sel, `SFL_SEL_TIMER);
  wire wr_pd    = le_rise & sel_is(sel, `SFL_SEL_PWRDN);
  wire wr_diag  = le_rise & sel_is(sel, `SFL_SEL_DIAG);
  wire [1:0] tsel = shift_r[`SFL_TSEL_LSB +: 2];
  wire [`SFL_TMR_W-1:0] tval = shift_r[`SFL_TMR_LSB +: `SFL_TMR_W];
  wire [4:0] pd_new = shift_r[`SFL_PD_LSB +: 5];
  wire [3:0] dmode = shift_r[`SFL_DMODE_LSB +: 4];
  wire pump_off = pd_r[`SFL_PD_PUMP];
  wire apply = pend_r & ref_rise;

  // Every pin is foreign to sys_clk; third stage only feeds edge detects
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= (gi == P_SCK) ? ser_clk :
                         (gi == P_SDI) ? ser_data :
                         (gi == P_LE)  ? load_enable_strobe :
                         (gi == P_REF) ? pfd_ref :
                         (gi == P_FB)  ? fb_div : lock_detect_raw;
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  // Serial side stays alive through every power-down state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_r <= 24'h000000;
    end else if (sck_rise) begin
      shift_r <= {shift_r[`SFL_WORD_W-2:0], sync2_r[P_SDI]};
    end
  end

  // Register latching on the load strobe
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mod_hold_r <= `SFL_MOD_MIN;
      phase_hold_r <= 12'h000;
      int_hold_r <= 8'h00;
      fractional_numerator_hold_r <= 12'h000;
      tmr_cur_load_r <= 9'h000;
      tmr_swab_load_r <= 9'h000;
      tmr_swc_load_r <= 9'h000;
      pd_r <= `SFL_PD_RESET;
      dmux_r <= `SFL_DMUX_LOW;
      pump_ground_n_r <= 1'b0;
      pfd_positive_r <= 1'b0;
      dither_en_r <= 1'b0;
      lock_thresh_10ns_r <= 1'b0;
      seen_phase_r <= 1'b0;
      seen_mod_r <= 1'b0;
    end else begin
      if (wr_freq) begin
        int_hold_r <= shift_r[`SFL_INT_LSB +: `SFL_INT_W];
        fractional_numerator_hold_r <= shift_r[`SFL_FRACTIONAL_NUMERATOR_LSB +: `SFL_FRACTIONAL_NUMERATOR_W];
      end
      if (wr_mod) begin
        mod_hold_r <= shift_r[`SFL_MOD_LSB +: `SFL_MOD_W];
        seen_mod_r <= 1'b1;
      end
      if (wr_phase) begin
        phase_hold_r <= shift_r[`SFL_PHASE_LSB +: `SFL_MOD_W];
        seen_phase_r <= 1'b1;
      end
      if (wr_func) begin
        pump_ground_n_r <= shift_r[`SFL_FUNC_GND_BIT];
        pfd_positive_r <= shift_r[`SFL_FUNC_POL_BIT];
      end
      if (wr_tmr) begin
        case (tsel)
          `SFL_TSEL_CUR:  tmr_cur_load_r <= tval;
          `SFL_TSEL_SWAB: tmr_swab_load_r <= tval;
          `SFL_TSEL_SWC:  tmr_swc_load_r <= tval;
          default: ;
        endcase
      end
      if (wr_pd) begin
        pd_r <= pd_new;
      end
      if (wr_diag) begin
        dmux_r <= shift_r[`SFL_DMUX_LSB +: 4];
        // Other mode codes are ignored so a stray write keeps state
        case (dmode)
          `SFL_DMODE_DEFAULT: begin
            dither_en_r <= 1'b0;
            lock_thresh_10ns_r <= 1'b0;
          end
          `SFL_DMODE_DITHER: dither_en_r <= 1'b1;
          `SFL_DMODE_LD10NS: lock_thresh_10ns_r <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Apply on the reference edge after a frequency write, run timers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      halted_r <= 1'b1;
      device_active_r <= 1'b0;
      int_value_r <= 8'h00;
      fractional_numerator_r <= 12'h000;
      fractional_modulus_r <= `SFL_MOD_MIN;
      modulator_seed_r <= 12'h000;
      seed_load_r <= 1'b0;
      presc_r <= 2'h0;
      tmr_cur_r <= 9'h000;
      tmr_swab_r <= 9'h000;
      tmr_swc_r <= 9'h000;
      ramp_r <= 1'b0;
      pump_current_mult_r <= `SFL_CUR_MIN;
    end else begin
      seed_load_r <= 1'b0;
      if (pump_off | pd_r[`SFL_PD_CRST]) begin
        halted_r <= 1'b1;
      end else if (wr_freq) begin
        halted_r <= 1'b0;
      end
      // Amp bits gate every activation on a frequency write; an amp power-down leaves the loop alone
      if (pump_off) begin
        device_active_r <= 1'b0;
      end else if (wr_freq & seen_phase_r & seen_mod_r & ~amp_power_down_r) begin
        device_active_r <= 1'b1;
      end
      if (wr_freq) begin
        pend_r <= 1'b1;
      end else if (apply) begin
        pend_r <= 1'b0;
      end
      if (halted_r) begin
        presc_r <= 2'h0;
        tmr_cur_r <= 9'h000;
        tmr_swab_r <= 9'h000;
        tmr_swc_r <= 9'h000;
        ramp_r <= 1'b0;
        pump_current_mult_r <= `SFL_CUR_MIN;
      end else if (apply) begin
        int_value_r <= int_hold_r;
        fractional_numerator_r <= fractional_numerator_hold_r;
        fractional_modulus_r <= mod_hold_r;
        modulator_seed_r <= phase_hold_r;
        seed_load_r <= 1'b1;
        presc_r <= 2'h0;
        tmr_cur_r <= tmr_cur_load_r;
        tmr_swab_r <= tmr_swab_load_r;
        tmr_swc_r <= tmr_swc_load_r;
        ramp_r <= 1'b1;
        pump_current_mult_r <= `SFL_CUR_MAX;
      end else begin
        if (ref_rise) begin
          presc_r <= presc_r + 2'h1;
        end
        if (qtick) begin
          if (tmr_cur_r != 9'h000) begin
            tmr_cur_r <= tmr_cur_r - 9'h001;
          end else if (ramp_r) begin
            // One halving per quarter tick: ramp spans six ticks
            pump_current_mult_r <= pump_current_mult_r >> 1;
            if (pump_current_mult_r == 7'h02) begin
              ramp_r <= 1'b0;
            end
          end
          if (tmr_swab_r != 9'h000) begin
            tmr_swab_r <= tmr_swab_r - 9'h001;
          end
          if (tmr_swc_r != 9'h000) begin
            tmr_swc_r <= tmr_swc_r - 9'h001;
          end
        end
      end
    end
  end

  always @* begin
    case (dmux_r)
      `SFL_DMUX_LOW:     diag_nxt = 1'b0;
      `SFL_DMUX_REFDIV:  diag_nxt = sync2_r[P_REF];
      `SFL_DMUX_FBDIV:   diag_nxt = sync2_r[P_FB];
      `SFL_DMUX_LOCK:    diag_nxt = sync2_r[P_LD] & ~pump_off;
      `SFL_DMUX_CURTMR:  diag_nxt = (tmr_cur_r != 9'h000);
      `SFL_DMUX_SWABTMR: diag_nxt = (tmr_swab_r != 9'h000);
      `SFL_DMUX_SWCTMR:  diag_nxt = (tmr_swc_r != 9'h000);
      `SFL_DMUX_HIGH:    diag_nxt = 1'b1;
      default:           diag_nxt = 1'b0;
    endcase
  end

  // Pin-facing controls, all registered
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bandwidth_switch_a_r <= 1'b0;
      bandwidth_switch_b_r <= 1'b0;
      bandwidth_switch_c_r <= 1'b0;
      amp_power_down_r <= 1'b1;
      pump_power_down_r <= 1'b1;
      dividers_load_r <= 1'b1;
      pump_tristate_r <= 1'b1;
      lock_detect_reset_r <= 1'b1;
      ref_buffer_en_r <= 1'b0;
      diagnostic_output_pin_r <= 1'b0;
    end else begin
      bandwidth_switch_a_r <= (tmr_swab_r != 9'h000);
      bandwidth_switch_b_r <= (tmr_swab_r != 9'h000);
      bandwidth_switch_c_r <= (tmr_swc_r != 9'h000);
      // Mixed amp bits keep the previous state
      if (pd_r[`SFL_PD_AMP_HI] & pd_r[`SFL_PD_AMP_LO]) begin
        amp_power_down_r <= 1'b1;
      end else if (~pd_r[`SFL_PD_AMP_HI] & ~pd_r[`SFL_PD_AMP_LO]) begin
        amp_power_down_r <= 1'b0;
      end
      pump_power_down_r <= pump_off | ~device_active_r;
      dividers_load_r <= pump_off | halted_r;
      pump_tristate_r <= pump_off | pd_r[`SFL_PD_TRI];
      lock_detect_reset_r <= pump_off;
      ref_buffer_en_r <= ~pump_off;
      diagnostic_output_pin_r <= diag_nxt;
    end
  end

endmodule

// [hw/sfl_defines.vh]
`ifndef SFL_DEFINES_VH
`define SFL_DEFINES_VH
// Register select codes in the three low bits of a serial word
`define SFL_SEL_FREQ      3'h0
`define SFL_SEL_MODDIV    3'h1
`define SFL_SEL_PHASE     3'h2
`define SFL_SEL_FUNC      3'h3
`define SFL_SEL_TIMER     3'h4
`define SFL_SEL_PWRDN     3'h5
`define SFL_SEL_DIAG      3'h6
`define SFL_WORD_W        24
// Frequency word fields
`define SFL_INT_LSB       15
`define SFL_INT_W         8
`define SFL_FRACTIONAL_NUMERATOR_LSB      3
`define SFL_FRACTIONAL_NUMERATOR_W        12
// Modulus field and host range
`define SFL_MOD_LSB       3
`define SFL_MOD_W         12
`define SFL_MOD_MIN       12'h00d
`define SFL_MOD_MAX       12'hfff
// Phase seed field
`define SFL_PHASE_LSB     3
// Function bits
`define SFL_FUNC_GND_BIT  5
`define SFL_FUNC_POL_BIT  3
// Timer word fields and select codes
`define SFL_TMR_LSB       5
`define SFL_TMR_W         9
`define SFL_TSEL_LSB      3
`define SFL_TSEL_CUR      2'h2
`define SFL_TSEL_SWAB     2'h1
`define SFL_TSEL_SWC      2'h0
`define SFL_TMR_PRESC     2'h3
`define SFL_CUR_MAX       7'h40
`define SFL_CUR_MIN       7'h01
// Power-down bits (word bit 7 down to bit 3)
`define SFL_PD_LSB        3
`define SFL_PD_AMP_HI     4
`define SFL_PD_AMP_LO     3
`define SFL_PD_PUMP       2
`define SFL_PD_TRI        1
`define SFL_PD_CRST       0
`define SFL_PD_RESET      5'h1f
// Diagnostic mode word
`define SFL_DMODE_LSB     12
`define SFL_DMODE_DEFAULT 4'h0
`define SFL_DMODE_DITHER  4'h3
`define SFL_DMODE_LD10NS  4'h9
`define SFL_DMUX_LSB      3
`define SFL_DMUX_LOW      4'h0
`define SFL_DMUX_REFDIV   4'h1
`define SFL_DMUX_FBDIV    4'h2
`define SFL_DMUX_LOCK     4'h3
`define SFL_DMUX_CURTMR   4'h4
`define SFL_DMUX_SWABTMR  4'h5
`define SFL_DMUX_SWCTMR   4'h6
`define SFL_DMUX_HIGH     4'hf
`endif

// [verification/sfl_ctrl_properties.sv]
`timescale 1ns/100ps
module sfl_ctrl_properties (
  input wire        sys_clk,
  input wire        rst,
  input wire        seed_load_r,
  input wire [11:0] modulator_seed_r,
  input wire [6:0]  pump_current_mult_r,
  input wire        bandwidth_switch_a_r,
  input wire        bandwidth_switch_b_r,
  input wire        bandwidth_switch_c_r,
  input wire        pump_power_down_r,
  input wire        pump_tristate_r,
  input wire        dividers_load_r,
  input wire        lock_detect_reset_r,
  input wire        ref_buffer_en_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_mult_one_hot: assert property ($onehot(pump_current_mult_r))
    else $error("multiplier not one-hot");
  // A halt may drop straight to unity and an apply jumps to full, so only those two jumps are let through
  a_mult_halving: assert property ($changed(pump_current_mult_r) |->
    (pump_current_mult_r == 7'h40 || pump_current_mult_r == 7'h01 ||
     pump_current_mult_r == ($past(pump_current_mult_r) >> 1)))
    else $error("multiplier step wrong");
  a_apply_full: assert property (seed_load_r |-> pump_current_mult_r == 7'h40)
    else $error("apply without full current");
  a_apply_pulse: assert property (seed_load_r |=> !seed_load_r)
    else $error("apply pulse too long");
  a_seed_held: assert property ($changed(modulator_seed_r) |-> seed_load_r)
    else $error("seed moved without apply");
  a_switch_start: assert property ($rose(bandwidth_switch_c_r) |-> $past(seed_load_r))
    else $error("switch closed without apply");
  a_switch_pair: assert property (bandwidth_switch_a_r == bandwidth_switch_b_r)
    else $error("switch pair split");
  a_pump_off: assert property (!ref_buffer_en_r |-> pump_tristate_r &&
    dividers_load_r && lock_detect_reset_r && pump_power_down_r)
    else $error("pump power-down incomplete");
  a_halt_idle: assert property (pump_power_down_r [*3] |->
    pump_current_mult_r == 7'h01 && !bandwidth_switch_c_r)
    else $error("halted loop still active");
  c_apply: cover property (seed_load_r);
  c_ramp_end: cover property ($fell(bandwidth_switch_c_r));
  c_pump_off: cover property ($rose(pump_power_down_r));
endmodule

bind sfl_ctrl sfl_ctrl_properties sfl_ctrl_properties_i (.sys_clk, .rst, .seed_load_r,
  .modulator_seed_r, .pump_current_mult_r, .bandwidth_switch_a_r, .bandwidth_switch_b_r,
  .bandwidth_switch_c_r, .pump_power_down_r, .pump_tristate_r, .dividers_load_r,
  .lock_detect_reset_r, .ref_buffer_en_r);

// [verification/sfl_ctrl_test.sv]
`timescale 1ns/100ps
module sfl_ctrl_test;
  reg         sys_clk;
  reg         rst;
  reg         pfd_ref;
  reg         fb_div;
  reg         lock_detect_raw;
  wire        ser_clk;
  wire        ser_data;
  wire        load_enable_strobe;
  wire [7:0]  int_value_r;
  wire [11:0] fractional_numerator_r;
  wire [11:0] fractional_modulus_r;
  wire [11:0] modulator_seed_r;
  wire        pump_ground_n_r;
  wire        pfd_positive_r;
  wire        bandwidth_switch_a_r;
  wire        bandwidth_switch_c_r;
  wire        lock_detect_reset_r;
  wire [6:0]  pump_current_mult_r;
  wire        amp_power_down_r;
  wire        pump_power_down_r;
  wire        dividers_load_r;
  wire        pump_tristate_r;
  wire        ref_buffer_en_r;
  wire        dither_en_r;
  wire        lock_thresh_10ns_r;
  wire        diagnostic_output_pin_r;
  wire        device_active_r;
  integer     n_mismatch;
  integer     comparisons;
  integer     n;
  integer     cyc_count;
  integer     last_freq;
  sfl_ctrl sfl_ctrl_i (.sys_clk, .rst, .ser_clk, .ser_data, .load_enable_strobe, .pfd_ref,
    .fb_div, .lock_detect_raw, .int_value_r, .fractional_numerator_r, .fractional_modulus_r,
    .modulator_seed_r, .seed_load_r(), .pump_ground_n_r, .pfd_positive_r,
    .bandwidth_switch_a_r, .bandwidth_switch_b_r(), .bandwidth_switch_c_r,
    .pump_current_mult_r, .amp_power_down_r, .pump_power_down_r, .dividers_load_r,
    .pump_tristate_r, .lock_detect_reset_r, .ref_buffer_en_r, .dither_en_r,
    .lock_thresh_10ns_r, .diagnostic_output_pin_r, .device_active_r);
  sfl_host sfl_host_i (.sys_clk, .ser_clk, .ser_data, .load_enable_strobe);
  always #12.5 sys_clk = ~sys_clk;
  always #100 pfd_ref = ~pfd_ref;
  always @(posedge sys_clk) cyc_count <= cyc_count + 1;
  task cyc(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
    end
  endtask
  task chk(input [11:0] got, input [11:0] exp, input [79:0] m);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t %0s", $time, m);
      end
    end
  endtask
  // Frequency writes settle on a reference edge, so they get extra time
  // Frequency writes are spaced by whole modulus periods of 65 reference cycles of 8 clocks
  task wr(input [23:0] w);
    begin
      if (w[2:0] == 3'h0 && last_freq >= 0) begin
        while ((cyc_count - last_freq) % (65 * 8) != 0) cyc(1);
      end
      if (w[2:0] == 3'h0) begin
        last_freq = cyc_count;
      end
      sfl_host_i.send(w);
      cyc(w[2:0] == 3'h0 ? 20 : 8);
    end
  endtask
  task final_report;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task t_powerup;
    begin
      chk(device_active_r, 0, "rst act");
      chk(pump_tristate_r, 1, "rst tri");
      wr(24'h000005);
      chk(amp_power_down_r, 0, "amp on");
      wr(24'h0000d2);
      wr(24'h000209);
      wr(24'h00007b);
      wr(24'h004054);
      wr(24'h00412c);
      wr(24'h004124);
      chk(modulator_seed_r, 0, "seed held");
      chk(device_active_r, 0, "early act");
      wr(24'h480140);
      chk(modulator_seed_r, 26, "seed");
      chk(fractional_modulus_r, 65, "modulus");
      chk(int_value_r, 144, "int");
      chk(fractional_numerator_r, 40, "fractional_numerator");
      chk(pump_current_mult_r, 7'h40, "fast cur");
      chk(bandwidth_switch_a_r, 1, "sw closed");
      chk(bandwidth_switch_c_r, 1, "sw c");
      chk(device_active_r, 1, "active");
    end
  endtask
  task t_ramp;
    begin
      n = 0;
      while (pump_current_mult_r !== 7'h01 && n < 2000) begin
        cyc(1);
        n = n + 1;
      end
      chk(pump_current_mult_r, 1, "ramp end");
      chk(bandwidth_switch_a_r, 1, "sw early");
      if (n >= 2000) final_report;
      n = 0;
      while (bandwidth_switch_a_r !== 1'b0 && n < 2000) begin
        cyc(1);
        n = n + 1;
      end
      chk(n >= 28 && n <= 68, 1, "sw time");
      if (n >= 2000) final_report;
    end
  endtask
  task t_func;
    begin
      wr(24'h00005b);
      chk(pump_ground_n_r, 0, "grounded");
      chk(pfd_positive_r, 1, "pol pos");
      wr(24'h000073);
      chk(pump_ground_n_r, 1, "released");
      chk(pfd_positive_r, 0, "pol neg");
    end
  endtask
  task t_diag;
    begin
      wr(24'h00301e);
      chk(dither_en_r, 1, "dither");
      wr(24'h00901e);
      chk(lock_thresh_10ns_r, 1, "thr 10");
      chk(diagnostic_output_pin_r, 1, "mux lock");
      wr(24'h00001e);
      chk({dither_en_r, lock_thresh_10ns_r}, 0, "mode 0");
      wr(24'h000016);
      chk(diagnostic_output_pin_r, 0, "mux fb");
      wr(24'h00007e);
      chk(diagnostic_output_pin_r, 1, "mux high");
    end
  endtask
  task t_pd;
    begin
      wr(24'h0000c5);
      chk(amp_power_down_r, 1, "amp off");
      wr(24'h000005);
      chk(amp_power_down_r, 0, "amp on");
      wr(24'h000015);
      chk({pump_tristate_r, pump_power_down_r}, 2, "tri");
      wr(24'h000025);
      chk({dividers_load_r, ref_buffer_en_r, lock_detect_reset_r}, 5, "pump off");
      wr(24'h0000fa);
      wr(24'h00000d);
      chk({dividers_load_r, pump_power_down_r}, 3, "cnt rst");
      wr(24'h000005);
      chk(pump_power_down_r, 1, "pump held");
      wr(24'h000026);
      chk(diagnostic_output_pin_r, 0, "cur idle");
      wr(24'h480148);
      chk(dividers_load_r, 0, "resumed");
      chk(pump_power_down_r, 0, "pump on");
      chk(diagnostic_output_pin_r, 1, "cur pulse");
      chk(modulator_seed_r, 31, "seed kept");
      chk(fractional_numerator_r, 41, "fractional_numerator 2");
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    pfd_ref = 1'b0;
    rst = 1'b1;
    fb_div = 1'b0;
    lock_detect_raw = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    cyc_count = 0;
    last_freq = -1;
    cyc(4);
    rst <= 1'b0;
    cyc(4);
    t_powerup;
    t_ramp;
    t_func;
    t_diag;
    t_pd;
    final_report;
  end
endmodule

// [verification/sfl_host.sv]
`timescale 1ns/100ps
module sfl_host (
  input  wire sys_clk,
  output reg  ser_clk,
  output reg  ser_data,
  output reg  load_enable_strobe
);
  integer i;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_enable_strobe = 1'b0;
  end
  task hold(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) @(posedge sys_clk);
    end
  endtask
  // Four clocks per level leaves margin over the two-stage synchroniser
  task send(input [23:0] w);
    begin
      for (i = 23; i >= 0; i = i - 1) begin
        ser_data <= w[i];
        hold(4);
        ser_clk <= 1'b1;
        hold(4);
        ser_clk <= 1'b0;
      end
      ser_data <= ~w[0];
      hold(4);
      load_enable_strobe <= 1'b1;
      hold(4);
      load_enable_strobe <= 1'b0;
      hold(4);
    end
  endtask
endmodule
